//--- design/bphp_pkg.sv
// Purpose: constants and types of the burst packet host port controller
// Assumes: 250 MHz core clock, 1 Mb/s serial clock made by division
// Notes:   offsets are byte addresses on a 32-bit APB slave
package bphp_pkg;

  localparam int CLK_MHZ       = 250;
  localparam int CS_GAP_NS     = 5000;
  localparam int CS_GAP_CYC    = (CS_GAP_NS * CLK_MHZ + 999) / 1000;
  localparam int LOAD_WAIT_NS  = 20000;
  localparam int LOAD_WAIT_CYC = (LOAD_WAIT_NS * CLK_MHZ + 999) / 1000;
  localparam int SCLK_HALF_NS  = 500;
  localparam int SCLK_HALF_CYC = (SCLK_HALF_NS * CLK_MHZ) / 1000;

  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CFGW = 8'h04;
  localparam logic [7:0] OFS_TXCH = 8'h08;
  localparam logic [7:0] OFS_RXCH = 8'h0c;
  localparam logic [7:0] OFS_LEN  = 8'h10;
  localparam logic [7:0] OFS_TXD  = 8'h14;
  localparam logic [7:0] OFS_RXD  = 8'h18;
  localparam logic [7:0] OFS_STAT = 8'h1c;

  localparam logic [15:0] CFGW_RST = 16'h0000;
  localparam logic [15:0] TXCH_RST = 16'h8088;  // tx_channel_word
  localparam logic [15:0] RXCH_RST = 16'h8008;  // rx_channel_word
  localparam logic [7:0]  LEN_RST  = 8'h04;

  localparam logic [7:0] CFG_BITS   = 8'd16;
  localparam logic [7:0] PAD_BITS   = 8'd3;
  localparam logic [7:0] DUMMY_BITS = 8'd2;
  localparam logic [7:0] TAIL_BITS  = 8'd3;

  localparam int ST_BUSY  = 0;
  localparam int ST_EVT   = 1;
  localparam int ST_TXF   = 2;
  localparam int ST_RXF   = 3;
  localparam int ST_DONE  = 4;
  localparam int ST_LOST  = 5;
  localparam int ST_SCLK  = 6;
  localparam int ST_STATE = 16;

  typedef enum logic [2:0] {
    CMD_NONE    = 3'h0,
    CMD_CFG     = 3'h1,
    CMD_TX      = 3'h2,
    CMD_RX      = 3'h3,
    CMD_STANDBY = 3'h4,
    CMD_SLEEP   = 3'h5
  } bphp_cmd_t;

  typedef enum logic [11:0] {
    S_IDLE      = 12'h001,
    S_CFG_SHIFT = 12'h002,
    S_CS_GAP    = 12'h004,
    S_LOAD_WAIT = 12'h008,
    S_TX_SHIFT  = 12'h010,
    S_TX_PAD    = 12'h020,
    S_TX_RUN    = 12'h040,
    S_RX_WAIT   = 12'h080,
    S_RX_DUMMY  = 12'h100,
    S_RX_SHIFT  = 12'h200,
    S_RX_TAIL   = 12'h400,
    S_SLEEP     = 12'h800
  } bphp_state_t;

endpackage : bphp_pkg

//--- design/bphp_sync2.sv
// Purpose: two-flop synchroniser for one pin level
// Assumes: input is asynchronous to clk_i
// Notes:   first flop feeds only the second one
`timescale 1ns/10ps
module bphp_sync2 (
  input  wire logic clk_i,    // core clock
  input  wire logic rst_n_i,  // async reset, active low
  input  wire logic d_i,      // asynchronous level
  output logic      q_o       // synchronised level
);
  logic meta_q;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_q <= 1'b0;
      q_o    <= 1'b0;
    end else begin
      meta_q <= d_i;
      q_o    <= meta_q;
    end
  end
endmodule : bphp_sync2

//--- design/bphp_host.sv
// Purpose: host controller that sequences the radio's burst packet port
// Assumes: APB slave for software; radio pins driven directly
// Notes:   serial clock derived from CLK_I; pin inputs synchronised
//
// Contract
// - standby: power line high, chip select and mode line low
// - config kept across modes; after sleep or power-up reconfigure
// - config mode: mode low, chip select and power line high
// - write tx channel word, then chip select low at least 5 us
// - chip select low, raise power and mode lines: load/receive mode
// - wait 20 us in load mode before the first transmit bit
// - count transmit bits, stop at configured depth
// - three extra clocks after payload; device substitutes addresses
// - mode line low after loading starts radio transmission
// - write rx channel word, chip select low 5 us, enter receive
// - readout starts with two discarded dummy clocks
// - check flag after each byte; when low read one last byte
// - three discarded clocks after last byte re-arm the receiver
// - host-written destination bytes precede payload, not returned
// - configured destination, no sender: payload bytes only
// - config write: 16 bits, write flag, 7-bit register, value byte
// - sleep: power line low, mode line high; leave by full reset; code also leaves sleep on a standby order
// - cycle chip select low at least 5 us between config writes
`timescale 1ns/10ps
module bphp_host #(
  parameter int LOAD_WAIT = bphp_pkg::LOAD_WAIT_CYC  // 20 us in cycles
) (
  input  wire logic        CLK_I,                // 250 MHz core clock
  input  wire logic        RESETN_I,             // async reset, low
  input  wire logic        PSEL_I,               // apb select
  input  wire logic        PENABLE_I,            // apb enable
  input  wire logic        PWRITE_I,             // apb direction
  input  wire logic [7:0]  PADDR_I,              // apb byte address
  input  wire logic [31:0] PWDATA_I,             // apb write data
  output logic      [31:0] PRDATA_O,             // apb read data
  output logic             PREADY_O,             // apb ready
  output logic             PSLVERR_O,            // apb error
  output logic             CS_O,                 // radio chip select
  output logic             POWER_SELECT_LINE_O,  // radio power-mode line
  output logic             MODE_O,               // radio mode line
  output logic             SCLK_O,               // serial clock
  output logic             DATA_O,               // serial data out
  output logic             DATA_OE_O,            // drive enable of data
  input  wire logic        DATA_I,               // serial data pin in
  input  wire logic        EVENT_I               // radio event flag
);
  bphp_pkg::bphp_state_t st_q, st_d;
  bphp_pkg::bphp_cmd_t   op_q;

  logic        data_s, evt_s;
  logic [15:0] cfgw_q, txch_q, rxch_q, sh_q;
  logic [7:0]  len_q, tx_byte_q, rx_byte_q, tx_left_q, bit_cnt_q;
  logic [15:0] wt_q;
  logic [7:0]  hc_q;
  logic        tx_full_q, rx_full_q, done_q, lost_q, last_q;
  logic        byte_go_q, sclk_q, rx_bit_q;
  logic        cs_q, pm_q, md_q;
  logic        acc, wr, rd, err_c, cmd_ok, cmd_go, chg;
  logic        run, half_end, bit_done, rise, byte_end, tx_take, rx_go;
  logic [2:0]  cmd_w;
  logic [31:0] rdata_c;

  bphp_sync2 u_sync_data (
    .clk_i   (CLK_I),
    .rst_n_i (RESETN_I),
    .d_i     (DATA_I),
    .q_o     (data_s)
  );

  bphp_sync2 u_sync_evt (
    .clk_i   (CLK_I),
    .rst_n_i (RESETN_I),
    .d_i     (EVENT_I),
    .q_o     (evt_s)
  );

  // apb: zero-wait access phase, read data captured in the setup cycle
  assign acc      = PSEL_I & PENABLE_I;
  assign wr       = acc & PWRITE_I;
  assign rd       = acc & ~PWRITE_I;
  assign PREADY_O = acc;
  assign cmd_w    = PWDATA_I[2:0];

  always_comb begin
    cmd_ok = 1'b0;
    case (cmd_w)
      bphp_pkg::CMD_STANDBY, bphp_pkg::CMD_SLEEP: cmd_ok = 1'b1;
      bphp_pkg::CMD_CFG, bphp_pkg::CMD_TX, bphp_pkg::CMD_RX:
        cmd_ok = (st_q == bphp_pkg::S_IDLE);
      default: cmd_ok = 1'b0;
    endcase
  end

  always_comb begin
    err_c = 1'b0;
    case (PADDR_I)
      bphp_pkg::OFS_CTRL: err_c = PWRITE_I & ~cmd_ok;
      bphp_pkg::OFS_TXD:  err_c = PWRITE_I & tx_full_q;
      bphp_pkg::OFS_RXD:  err_c = PWRITE_I;
      bphp_pkg::OFS_CFGW, bphp_pkg::OFS_TXCH, bphp_pkg::OFS_RXCH,
      bphp_pkg::OFS_LEN, bphp_pkg::OFS_STAT: err_c = 1'b0;
      default: err_c = 1'b1;
    endcase
  end

  assign PSLVERR_O = acc & err_c;
  assign cmd_go    = wr & ~err_c & (PADDR_I == bphp_pkg::OFS_CTRL);

  always_comb begin
    rdata_c = 32'h0000_0000;
    case (PADDR_I)
      bphp_pkg::OFS_CTRL: rdata_c[2:0]  = op_q;
      bphp_pkg::OFS_CFGW: rdata_c[15:0] = cfgw_q;
      bphp_pkg::OFS_TXCH: rdata_c[15:0] = txch_q;
      bphp_pkg::OFS_RXCH: rdata_c[15:0] = rxch_q;
      bphp_pkg::OFS_LEN:  rdata_c[7:0]  = len_q;
      bphp_pkg::OFS_TXD:  rdata_c[7:0]  = tx_byte_q;
      bphp_pkg::OFS_RXD:  rdata_c[7:0]  = rx_byte_q;
      bphp_pkg::OFS_STAT: begin
        rdata_c[bphp_pkg::ST_BUSY] = (st_q != bphp_pkg::S_IDLE) &&
                                     (st_q != bphp_pkg::S_SLEEP);
        rdata_c[bphp_pkg::ST_EVT]  = evt_s;
        rdata_c[bphp_pkg::ST_TXF]  = tx_full_q;
        rdata_c[bphp_pkg::ST_RXF]  = rx_full_q;
        rdata_c[bphp_pkg::ST_DONE] = done_q;
        rdata_c[bphp_pkg::ST_LOST] = lost_q;
        rdata_c[bphp_pkg::ST_SCLK] = sclk_q;
        rdata_c[bphp_pkg::ST_STATE +: 12] = st_q;
      end
      default: rdata_c = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      PRDATA_O <= 32'h0000_0000;
    end else if (PSEL_I && !PENABLE_I && !PWRITE_I) begin
      PRDATA_O <= rdata_c;
    end
  end

  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      cfgw_q <= bphp_pkg::CFGW_RST;
      txch_q <= bphp_pkg::TXCH_RST;
      rxch_q <= bphp_pkg::RXCH_RST;
      len_q  <= bphp_pkg::LEN_RST;
    end else if (wr) begin
      case (PADDR_I)
        bphp_pkg::OFS_CFGW: cfgw_q <= PWDATA_I[15:0];
        bphp_pkg::OFS_TXCH: txch_q <= PWDATA_I[15:0];
        bphp_pkg::OFS_RXCH: rxch_q <= PWDATA_I[15:0];
        bphp_pkg::OFS_LEN:  len_q  <= PWDATA_I[7:0];
        default: ;
      endcase
    end
  end

  // sequencer
  assign chg = (st_d != st_q);

  always_comb begin
    st_d = st_q;
    case (st_q)
      bphp_pkg::S_IDLE:
        if (cmd_go && (cmd_w == bphp_pkg::CMD_CFG || cmd_w ==
            bphp_pkg::CMD_TX || cmd_w == bphp_pkg::CMD_RX)) begin
          st_d = bphp_pkg::S_CFG_SHIFT;
        end
      bphp_pkg::S_CFG_SHIFT:
        if (bit_done && bit_cnt_q == bphp_pkg::CFG_BITS - 8'd1) begin
          st_d = bphp_pkg::S_CS_GAP;
        end
      bphp_pkg::S_CS_GAP:
        if (wt_q == 16'(bphp_pkg::CS_GAP_CYC - 1)) begin
          case (op_q)
            bphp_pkg::CMD_TX: st_d = bphp_pkg::S_LOAD_WAIT;
            bphp_pkg::CMD_RX: st_d = bphp_pkg::S_RX_WAIT;
            default:          st_d = bphp_pkg::S_IDLE;
          endcase
        end
      bphp_pkg::S_LOAD_WAIT:
        if (wt_q == 16'(LOAD_WAIT - 1)) begin
          st_d = (len_q == 8'd0) ? bphp_pkg::S_TX_PAD
                                 : bphp_pkg::S_TX_SHIFT;
        end
      bphp_pkg::S_TX_SHIFT:
        if (byte_end && tx_left_q == 8'd1) begin
          st_d = bphp_pkg::S_TX_PAD;
        end
      bphp_pkg::S_TX_PAD:
        if (bit_done && bit_cnt_q == bphp_pkg::PAD_BITS - 8'd1) begin
          st_d = bphp_pkg::S_TX_RUN;
        end
      bphp_pkg::S_TX_RUN:
        if (evt_s) begin
          st_d = bphp_pkg::S_IDLE;
        end
      bphp_pkg::S_RX_WAIT:
        if (evt_s) begin
          st_d = bphp_pkg::S_RX_DUMMY;
        end
      bphp_pkg::S_RX_DUMMY:
        if (bit_done && bit_cnt_q == bphp_pkg::DUMMY_BITS - 8'd1) begin
          st_d = bphp_pkg::S_RX_SHIFT;
        end
      bphp_pkg::S_RX_SHIFT:
        if (byte_end && last_q) begin
          st_d = bphp_pkg::S_RX_TAIL;
        end
      bphp_pkg::S_RX_TAIL:
        if (bit_done && bit_cnt_q == bphp_pkg::TAIL_BITS - 8'd1) begin
          st_d = bphp_pkg::S_RX_WAIT;
        end
      bphp_pkg::S_SLEEP: st_d = bphp_pkg::S_SLEEP;
      default:           st_d = bphp_pkg::S_IDLE;
    endcase
    // standby and sleep abort any sequence in flight
    if (cmd_go && cmd_w == bphp_pkg::CMD_STANDBY) begin
      st_d = bphp_pkg::S_IDLE;
    end
    if (cmd_go && cmd_w == bphp_pkg::CMD_SLEEP) begin
      st_d = bphp_pkg::S_SLEEP;
    end
  end

  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      st_q <= bphp_pkg::S_IDLE;
      op_q <= bphp_pkg::CMD_NONE;
    end else begin
      st_q <= st_d;
      if (cmd_go) begin
        op_q <= bphp_pkg::bphp_cmd_t'(cmd_w);
      end
    end
  end

  // control lines {chip select, power, mode} follow state entries
  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      cs_q <= 1'b0;
      pm_q <= 1'b1;
      md_q <= 1'b0;
    end else if (chg || cmd_go) begin
      // a standby order re-drives its levels even when already idle
      case (st_d)
        bphp_pkg::S_CFG_SHIFT: begin
          cs_q <= 1'b1;
          pm_q <= 1'b1;
          md_q <= 1'b0;
        end
        bphp_pkg::S_CS_GAP: cs_q <= 1'b0;
        bphp_pkg::S_LOAD_WAIT, bphp_pkg::S_RX_WAIT: begin
          if (st_q == bphp_pkg::S_CS_GAP) begin
            pm_q <= 1'b1;
            md_q <= 1'b1;
          end
        end
        bphp_pkg::S_TX_RUN: md_q <= 1'b0;
        bphp_pkg::S_SLEEP: begin
          cs_q <= 1'b0;
          pm_q <= 1'b0;
          md_q <= 1'b1;
        end
        bphp_pkg::S_IDLE: begin
          if (st_q == bphp_pkg::S_CS_GAP && !cmd_go) begin
            cs_q <= 1'b1;
          end else begin
            cs_q <= 1'b0;
            pm_q <= 1'b1;
            md_q <= 1'b0;
          end
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      wt_q <= 16'h0000;
    end else if (chg) begin
      wt_q <= 16'h0000;
    end else if (st_q == bphp_pkg::S_CS_GAP ||
                 st_q == bphp_pkg::S_LOAD_WAIT) begin
      wt_q <= wt_q + 16'h0001;
    end
  end

  // serial clock: low half presents data, rising edge samples
  assign run = (st_q == bphp_pkg::S_CFG_SHIFT) ||
               (st_q == bphp_pkg::S_TX_PAD) ||
               (st_q == bphp_pkg::S_RX_DUMMY) ||
               (st_q == bphp_pkg::S_RX_TAIL) ||
               (((st_q == bphp_pkg::S_TX_SHIFT) ||
                 (st_q == bphp_pkg::S_RX_SHIFT)) && byte_go_q);
  assign half_end = (hc_q == 8'(bphp_pkg::SCLK_HALF_CYC - 1));
  assign bit_done = run & half_end & sclk_q;
  assign rise     = run & half_end & ~sclk_q;
  assign byte_end = bit_done & (bit_cnt_q[2:0] == 3'd7) &
                    ((st_q == bphp_pkg::S_TX_SHIFT) ||
                     (st_q == bphp_pkg::S_RX_SHIFT));
  assign tx_take  = (st_q == bphp_pkg::S_TX_SHIFT) & ~byte_go_q &
                    tx_full_q;
  assign rx_go    = (st_q == bphp_pkg::S_RX_SHIFT) & ~byte_go_q &
                    ~rx_full_q;

  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      hc_q   <= 8'h00;
      sclk_q <= 1'b0;
    end else if (!run || chg) begin
      hc_q   <= 8'h00;
      sclk_q <= 1'b0;
    end else if (half_end) begin
      hc_q   <= 8'h00;
      sclk_q <= ~sclk_q;
    end else begin
      hc_q <= hc_q + 8'h01;
    end
  end

  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      bit_cnt_q <= 8'h00;
      rx_bit_q  <= 1'b0;
    end else begin
      if (chg) begin
        bit_cnt_q <= 8'h00;
      end else if (bit_done) begin
        bit_cnt_q <= bit_cnt_q + 8'h01;
      end
      if (rise) begin
        rx_bit_q <= data_s;
      end
    end
  end

  // a byte waits at its boundary until data is there or room is free
  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      byte_go_q <= 1'b0;
    end else if (chg || byte_end) begin
      byte_go_q <= 1'b0;
    end else if (tx_take || rx_go) begin
      byte_go_q <= 1'b1;
    end
  end

  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      sh_q <= 16'h0000;
    end else if (st_q == bphp_pkg::S_IDLE &&
                 st_d == bphp_pkg::S_CFG_SHIFT) begin
      case (cmd_w)
        bphp_pkg::CMD_TX: sh_q <= txch_q;
        bphp_pkg::CMD_RX: sh_q <= rxch_q;
        default:          sh_q <= cfgw_q;
      endcase
    end else if (tx_take) begin
      sh_q <= {tx_byte_q, 8'h00};
    end else if (bit_done) begin
      sh_q <= {sh_q[14:0], rx_bit_q};
    end
  end

  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      tx_left_q <= 8'h00;
    end else if (st_q == bphp_pkg::S_LOAD_WAIT) begin
      tx_left_q <= len_q;
    end else if (byte_end && st_q == bphp_pkg::S_TX_SHIFT) begin
      tx_left_q <= tx_left_q - 8'h01;
    end
  end

  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      last_q <= 1'b0;
    end else if (chg) begin
      last_q <= 1'b0;
    end else if (byte_end && st_q == bphp_pkg::S_RX_SHIFT && !evt_s) begin
      last_q <= 1'b1;
    end
  end

  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      tx_byte_q <= 8'h00;
      tx_full_q <= 1'b0;
    end else begin
      if (wr && !err_c && PADDR_I == bphp_pkg::OFS_TXD) begin
        tx_byte_q <= PWDATA_I[7:0];
        tx_full_q <= 1'b1;
      end else if (tx_take) begin
        tx_full_q <= 1'b0;
      end
    end
  end

  // received byte: a new byte wins over a read in the same cycle
  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      rx_byte_q <= 8'h00;
      rx_full_q <= 1'b0;
    end else if (byte_end && st_q == bphp_pkg::S_RX_SHIFT) begin
      rx_byte_q <= {sh_q[6:0], rx_bit_q};
      rx_full_q <= 1'b1;
    end else if (rd && PADDR_I == bphp_pkg::OFS_RXD) begin
      rx_full_q <= 1'b0;
    end
  end

  // done is set by the event, cleared by writing one; set wins
  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      done_q <= 1'b0;
      lost_q <= 1'b1;
    end else begin
      if (st_q == bphp_pkg::S_TX_RUN && evt_s) begin
        done_q <= 1'b1;
      end else if (wr && PADDR_I == bphp_pkg::OFS_STAT &&
                   PWDATA_I[bphp_pkg::ST_DONE]) begin
        done_q <= 1'b0;
      end
      if (st_d == bphp_pkg::S_SLEEP) begin
        lost_q <= 1'b1;
      end else if (st_q == bphp_pkg::S_CS_GAP && chg &&
                   op_q == bphp_pkg::CMD_CFG) begin
        lost_q <= 1'b0;
      end
    end
  end

  assign CS_O                = cs_q;
  assign POWER_SELECT_LINE_O = pm_q;
  assign MODE_O              = md_q;
  assign SCLK_O              = sclk_q;
  assign DATA_O              = sh_q[15];
  assign DATA_OE_O           = (st_q == bphp_pkg::S_CFG_SHIFT) ||
                               (st_q == bphp_pkg::S_TX_SHIFT) ||
                               (st_q == bphp_pkg::S_TX_PAD);

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RESETN_I);

  sequence s_pad_last;
    st_q == bphp_pkg::S_TX_PAD && bit_done && bit_cnt_q == 8'd2;
  endsequence

  property p_standby;
    cmd_go && cmd_w == bphp_pkg::CMD_STANDBY |=> !CS_O &&
      POWER_SELECT_LINE_O && !MODE_O;
  endproperty
  a_standby: assert property (p_standby)
    else $error("standby levels wrong");

  property p_cfg_lines;
    st_q == bphp_pkg::S_CFG_SHIFT |-> CS_O && POWER_SELECT_LINE_O &&
      !MODE_O;
  endproperty
  a_cfg_lines: assert property (p_cfg_lines)
    else $error("config levels wrong during word shift");

  property p_gap;
    st_q == bphp_pkg::S_CS_GAP && chg |-> !CS_O &&
      wt_q == 16'(bphp_pkg::CS_GAP_CYC - 1);
  endproperty
  a_gap: assert property (p_gap)
    else $error("chip select gap too short");

  property p_load;
    st_q == bphp_pkg::S_TX_SHIFT |-> !CS_O && POWER_SELECT_LINE_O &&
      MODE_O;
  endproperty
  a_load: assert property (p_load)
    else $error("load levels wrong while shifting payload");

  property p_pre_wait;
    st_q == bphp_pkg::S_LOAD_WAIT && chg |-> wt_q == 16'(LOAD_WAIT - 1);
  endproperty
  a_pre_wait: assert property (p_pre_wait)
    else $error("payload started before load delay");

  property p_fire;
    s_pad_last |=> st_q == bphp_pkg::S_TX_RUN ##0 !MODE_O ##1 !MODE_O;
  endproperty
  a_fire: assert property (p_fire)
    else $error("mode line not dropped after three pad clocks");

  property p_dummy;
    st_q == bphp_pkg::S_RX_DUMMY && bit_done && bit_cnt_q == 8'd1
      |=> st_q == bphp_pkg::S_RX_SHIFT && !rx_full_q |-> ##1 byte_go_q;
  endproperty
  a_dummy: assert property (p_dummy)
    else $error("readout did not follow two dummy clocks");

  property p_word16;
    st_q == bphp_pkg::S_CFG_SHIFT && bit_done && bit_cnt_q == 8'd15
      |=> st_q == bphp_pkg::S_CS_GAP ##1 !CS_O;
  endproperty
  a_word16: assert property (p_word16)
    else $error("config word not sixteen bits");

  property p_sleep;
    st_q == bphp_pkg::S_SLEEP |-> !POWER_SELECT_LINE_O && MODE_O;
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("sleep levels wrong");

  property p_sclk;
    $changed(sclk_q) && run && $past(run) |-> $past(half_end);
  endproperty
  a_sclk: assert property (p_sclk)
    else $error("serial clock moved off the half period");

endmodule : bphp_host

//--- bench/bphp_radio_model.sv
// Purpose: behavioural radio on the far side of the host port
// Assumes: lines decoded as levels, bits move on serial clock edges
// Notes:   only one rx packet is offered per receive entry
`timescale 1ns/10ps
module bphp_radio_model #(
  parameter int NRX = 3  // bytes offered on readout
) (
  input  wire logic        cs_i,    // chip select
  input  wire logic        pm_i,    // power-mode line
  input  wire logic        md_i,    // mode line
  input  wire logic        sclk_i,  // serial clock from host
  input  wire logic        din_i,   // resolved data wire
  output logic             dout_o,  // readout bit
  output logic             drv_o,   // radio drives data
  output logic             evt_o,   // event flag
  output logic [15:0]      cfg_o,   // last full config word
  output logic [7:0]       txb_o,   // first loaded tx byte
  output int               n_o      // clocks seen in last mode
);
  localparam logic [7:0] RXB [3] = '{8'haa, 8'h01, 8'h3c};
  wire logic [2:0] m = {cs_i, pm_i, md_i};
  logic [2:0]  m_q = 3'b010;
  logic [15:0] sh = 16'h0000;
  int          k = 0;
  initial {dout_o, evt_o, cfg_o, txb_o, n_o} = '0;
  assign drv_o = (m == 3'b011) && !cfg_o[7];
  // config survives every mode change; only a new word replaces it
  always @(m) begin
    if (m_q == 3'b110 && k == 16) cfg_o = sh;
    evt_o = 1'b0;
    if (m_q == 3'b011 && m == 3'b010 && cfg_o[7]) evt_o <= #2000 1'b1;
    if (m == 3'b011 && !cfg_o[7]) evt_o <= #2000 1'b1;
    n_o = k;
    k = 0;
    m_q = m;
  end
  always @(posedge sclk_i) begin
    if (m == 3'b110) sh = {sh[14:0], din_i};
    if (m == 3'b011 && cfg_o[7] && k < 8) txb_o = {txb_o[6:0], din_i};
    k++;
    if (drv_o && k == 2 + (NRX - 1) * 8) evt_o = 1'b0;
  end
  // two dummy clocks, then sender bytes ahead of payload
  always @(negedge sclk_i)
    dout_o = (k >= 2 && k < 2 + NRX * 8) ?
             RXB[(k - 2) / 8][7 - (k - 2) % 8] : ~dout_o;
endmodule : bphp_radio_model

//--- bench/testbench.sv
// Purpose: apb driven checks of the host port against a radio model
// Assumes: LOAD_WAIT shortened to 50 cycles
// Notes:   one config, one tx and one rx packet, then standby and sleep
`timescale 1ns/10ps
module testbench;
  localparam logic [7:0] RXB [3] = '{8'haa, 8'h01, 8'h3c};
  logic        clk = 1'b0, rstn = 1'b0, psel = 1'b0, pen = 1'b0;
  logic        pwr = 1'b0, pready, pslverr, e, cs, pm, md, sclk;
  logic        dout, oe, din, evt, rdout, rdrv;
  logic [7:0]  paddr = 8'h00, txb;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic [15:0] cfg;
  int          n, errors = 0, samples_checked = 0;
  always #2 clk = ~clk;
  // released wire shows the inverse so a stale bit cannot pass
  assign din = oe ? dout : rdrv ? rdout : ~dout;
  bphp_host #(.LOAD_WAIT(50)) uut (.CLK_I(clk), .RESETN_I(rstn),
    .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr),
    .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .CS_O(cs), .POWER_SELECT_LINE_O(pm),
    .MODE_O(md), .SCLK_O(sclk), .DATA_O(dout), .DATA_OE_O(oe),
    .DATA_I(din), .EVENT_I(evt));
  bphp_radio_model radio (.cs_i(cs), .pm_i(pm), .md_i(md), .sclk_i(sclk),
    .din_i(din), .dout_o(rdout), .drv_o(rdrv), .evt_o(evt),
    .cfg_o(cfg), .txb_o(txb), .n_o(n));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1; pwr <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb
  task automatic poll(input int b, input logic v);
    int i;
    apb(1'b0, bphp_pkg::OFS_STAT, 32'h0);
    for (i = 0; i < 8000 && r[b] !== v; i++)
      apb(1'b0, bphp_pkg::OFS_STAT, 32'h0);
    chk(r[b], v);
  endtask : poll
  task automatic lines(input logic [2:0] exp);
    repeat (2) @(negedge clk);
    chk({cs, pm, md}, exp);
  endtask : lines
  task automatic complete_run;
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : complete_run
  initial begin
    #300000;
    errors++;
    complete_run();
  end
  initial begin
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    apb(1'b0, bphp_pkg::OFS_STAT, 32'h0);
    chk(r[5], 1'b1);
    chk({cs, pm, md}, 3'b010);
    apb(1'b0, 8'h20, 32'h0);
    chk(e, 1'b1);
    apb(1'b1, bphp_pkg::OFS_RXD, 32'h0);
    chk(e, 1'b1);
    apb(1'b1, bphp_pkg::OFS_CFGW, 32'h8503);
    apb(1'b1, bphp_pkg::OFS_CTRL, 32'h1);
    lines(3'b110);
    poll(0, 1'b0);
    chk(cfg, 16'h8503);
    chk(r[5], 1'b0);
    apb(1'b1, bphp_pkg::OFS_CTRL, 32'h4);
    lines(3'b010);
    apb(1'b1, bphp_pkg::OFS_LEN, 32'h1);
    apb(1'b1, bphp_pkg::OFS_TXD, 32'ha5);
    apb(1'b1, bphp_pkg::OFS_CTRL, 32'h2);
    poll(4, 1'b1);
    chk(r[1], 1'b1);
    chk(cfg, 16'h8088);
    chk(txb, 8'ha5);
    chk(n, 11);
    apb(1'b1, bphp_pkg::OFS_CTRL, 32'h3);
    lines(3'b110);
    apb(1'b0, bphp_pkg::OFS_STAT, 32'h0);
    chk(r[1], 1'b0);
    for (int i = 0; i < 3; i++) begin
      poll(3, 1'b1);
      apb(1'b0, bphp_pkg::OFS_RXD, 32'h0);
      chk(r[7:0], RXB[i]);
    end
    poll(23, 1'b1);
    chk(cfg, 16'h8008);
    apb(1'b1, bphp_pkg::OFS_CTRL, 32'h4);
    lines(3'b010);
    chk(n, 29);
    apb(1'b1, bphp_pkg::OFS_CTRL, 32'h5);
    lines(3'b001);
    apb(1'b0, bphp_pkg::OFS_STAT, 32'h0);
    chk(r[5], 1'b1);
    complete_run();
  end
endmodule : testbench
